//--- bdcg_axes_model.sv
// Behavioural servo axes: error decay and smoothing after motion stops.
// Assumes: the bench holds moving high while a block is still running.
`timescale 1ns/100ps
`default_nettype none

module bdcg_axes_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bench control
  input wire logic moving,
  input wire logic [7:0] lag,
  input wire logic [16:0] err0,
  // Servo status
  output logic [3:0] smoothing_zero,
  output logic [67:0] position_error
);
  logic [16:0] err_reg;
  logic [7:0] idle_reg;

  // Error shrinks one unit a cycle, so settling time tracks err0
  always_ff @(posedge sys_clk) begin
    if (!rst_b || moving) begin
      err_reg <= err0;
      idle_reg <= 8'h0;
    end else begin
      if (err_reg != 17'h0)
        err_reg <= err_reg - 17'h1;
      if (idle_reg != 8'hFF)
        idle_reg <= idle_reg + 8'h1;
    end
  end
  assign smoothing_zero = (idle_reg >= lag) ? 4'hF : 4'h0;
  assign position_error = {4{err_reg}};
endmodule // bdcg_axes_model
`default_nettype wire

//--- bdcg_axis_inpos.v
// One axis: in-position compare against the active width.
// Assumes: error is an unsigned magnitude in the same unit as the widths.
`timescale 1ns/100ps
`default_nettype none
`include "bdcg_regs.vh"

module bdcg_axis_inpos (
  // Widths
  input wire [`BDCG_WID_W-1:0] servo_inpos_width,
  input wire [`BDCG_WID_W-1:0] feed_axis_width,
  // Axis state
  input wire [`BDCG_WID_W-1:0] position_error,
  // Result
  output wire in_position
);

  wire use_feed;
  wire [`BDCG_WID_W-1:0] active_width;

  // Zero feed width means unset
  assign use_feed = (feed_axis_width != 17'h00000) &&
                    (feed_axis_width > servo_inpos_width);
  assign active_width = use_feed ? feed_axis_width : servo_inpos_width;
  assign in_position = position_error < active_width;

endmodule // bdcg_axis_inpos

`default_nettype wire

//--- bdcg_axis_td.v
// One axis: deceleration check time in milliseconds.
// Assumes: mode and constant already chosen for rapid or cutting feed.
`timescale 1ns/100ps
`default_nettype none
`include "bdcg_regs.vh"

module bdcg_axis_td (
  // Axis setup
  input wire [1:0] accel_mode,
  input wire [`BDCG_TS_W-1:0] accel_time_constant,
  input wire axis_commanded,
  // Result
  output reg [`BDCG_TD_W-1:0] decel_check_time
);

  wire [`BDCG_TD_W-1:0] ts_ext;

  assign ts_ext = {2'h0, accel_time_constant};

  always @* begin
    if (!axis_commanded) begin
      decel_check_time = 18'h00000;
    end else if (accel_mode == `BDCG_MODE_EXP) begin
      decel_check_time = (ts_ext << 1) + `BDCG_MARGIN_MS;
    end else if (accel_mode == `BDCG_MODE_SOFT) begin
      decel_check_time = ts_ext + `BDCG_MARGIN_MS;
    end else begin
      decel_check_time = ts_ext + `BDCG_MARGIN_MS;
    end
  end

endmodule // bdcg_axis_td

`default_nettype wire

//--- bdcg_chk.sv
// Checker for the block deceleration check gate, bound to its top.
// Assumes: one clock, sys_clk; rst_b synchronous and active low.
`timescale 1ns/100ps
`default_nettype none
`include "bdcg_regs.vh"

module bdcg_chk #(
  parameter int MS_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Block sequencer
  input wire logic block_end,
  input wire logic block_moved,
  input wire logic block_is_rapid,
  input wire logic block_exact_stop,
  input wire logic exact_stop_mode,
  input wire logic error_detect_switch,
  input wire logic [3:0] axis_reversal,
  // Servo axes
  input wire logic [3:0] smoothing_zero,
  // Status
  input wire logic block_release,
  input wire logic gate_busy,
  input wire logic [1:0] active_method,
  input wire logic [17:0] block_completion_wait
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [31:0] cnt_reg;
  wire es_any = block_exact_stop || exact_stop_mode || error_detect_switch;
  wire take = block_end && !gate_busy && !block_release;

  // Cycles since the last accepted block end
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      cnt_reg <= 32'h0;
    else if (take)
      cnt_reg <= 32'h1;
    else
      cnt_reg <= cnt_reg + 32'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_taken;
    take;
  endsequence
  sequence s_moved;
    s_taken ##0 block_moved;
  endsequence

  a_release_pulse: assert property (block_release |=> !block_release)
    else $error("release wider than one cycle");
  a_rapid_checked: assert property (s_moved ##0 block_is_rapid
    |=> gate_busy && active_method != 2'h3)
    else $error("rapid block end not checked");
  a_cut_free: assert property (s_moved ##0 (!block_is_rapid && !es_any
    && axis_reversal == 4'h0) |=> block_release && active_method == 2'h3)
    else $error("plain cutting end was held");
  a_cut_checked: assert property (s_moved ##0 (!block_is_rapid && es_any)
    |=> gate_busy && active_method != 2'h3)
    else $error("exact stop cutting end not checked");
  a_still_free: assert property (s_taken ##0 !block_moved
    |=> block_release && block_completion_wait == 18'h0)
    else $error("block without motion was held");
  a_smooth_waits: assert property ((gate_busy
    && active_method == `BDCG_METH_SMOOTH && smoothing_zero != 4'hF)[*2]
    |=> !block_release)
    else $error("release before smoothing reached zero");
  a_inpos_waits: assert property (gate_busy
    && active_method == `BDCG_METH_INPOS && smoothing_zero != 4'hF
    && $past(smoothing_zero) != 4'hF |=> !block_release)
    else $error("in-position release while still smoothing");
  a_decel_min: assert property (block_release && active_method != 2'h3
    |-> cnt_reg >= block_completion_wait * MS_CYCLES)
    else $error("release before the deceleration time");
  a_decel_bound: assert property (gate_busy
    && active_method == `BDCG_METH_CMD
    |-> cnt_reg <= block_completion_wait * (MS_CYCLES + 1) + 3)
    else $error("command wait runs too long");
endmodule // bdcg_chk

bind bdcg_top bdcg_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .sys_clk, .rst_b, .block_end, .block_moved, .block_is_rapid,
  .block_exact_stop, .exact_stop_mode, .error_detect_switch,
  .axis_reversal, .smoothing_zero, .block_release, .gate_busy,
  .active_method, .block_completion_wait);
`default_nettype wire

//--- bdcg_regs.vh
// Constants for the block deceleration check gate.
// Assumes: included by bare name from every design file of the gate.
`ifndef BDCG_REGS_VH
`define BDCG_REGS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define BDCG_AXES 4
`define BDCG_TS_W 16
`define BDCG_TD_W 18
`define BDCG_WID_W 17

// ----------------------------------------
// Timing
// ----------------------------------------
`define BDCG_CLK_PERIOD_NS 10
`define BDCG_MS_NS 1000000
`define BDCG_MARGIN_MS 18'h00001

// ----------------------------------------
// Acceleration modes
// ----------------------------------------
`define BDCG_MODE_LINEAR 2'h0
`define BDCG_MODE_EXP 2'h1
`define BDCG_MODE_SOFT 2'h2

// ----------------------------------------
// Check methods
// ----------------------------------------
`define BDCG_METH_CMD 2'h0
`define BDCG_METH_INPOS 2'h1
`define BDCG_METH_SMOOTH 2'h2
`define BDCG_METH_NONE 2'h3

`endif

//--- bdcg_top.v
// Block-completion gate: decides when the next motion block may start.
// Assumes: all inputs come from logic on sys_clk; block_end is a pulse.
`timescale 1ns/100ps
`default_nettype none
`include "bdcg_regs.vh"

module bdcg_top #(
  parameter MS_CYCLES = `BDCG_MS_NS / `BDCG_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Block sequencer
  input wire block_end,
  input wire block_moved,
  input wire block_is_rapid,
  input wire block_exact_stop,
  input wire exact_stop_mode,
  input wire error_detect_switch,
  input wire next_is_rapid,
  input wire next_is_cut,
  input wire [`BDCG_AXES-1:0] axis_commanded,
  input wire [`BDCG_AXES-1:0] axis_reversal,
  // Configuration
  input wire spec_type_select,
  input wire [1:0] rapid_method_select,
  input wire cutting_method_bit,
  input wire cutting_smoothing_select,
  input wire cut_to_rapid_reversal_flag,
  input wire cut_to_cut_reversal_flag,
  // Per-axis acceleration setup
  input wire [2*`BDCG_AXES-1:0] rapid_accel_mode,
  input wire [`BDCG_TS_W*`BDCG_AXES-1:0] rapid_time_constant,
  input wire [2*`BDCG_AXES-1:0] cutting_accel_mode,
  input wire [`BDCG_TS_W*`BDCG_AXES-1:0] cutting_time_constant,
  // Per-axis in-position widths
  input wire [`BDCG_WID_W*`BDCG_AXES-1:0] servo_inpos_width,
  input wire [`BDCG_WID_W*`BDCG_AXES-1:0] rapid_axis_inpos_width,
  input wire [`BDCG_WID_W*`BDCG_AXES-1:0] cutting_axis_inpos_width,
  // Servo axes
  input wire [`BDCG_AXES-1:0] smoothing_zero,
  input wire [`BDCG_WID_W*`BDCG_AXES-1:0] position_error,
  // Status
  output reg block_release,
  output reg gate_busy,
  output reg [1:0] active_method,
  output reg [`BDCG_TD_W-1:0] block_completion_wait
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DECEL = 5'h02;
  localparam [4:0] ST_SMOOTH = 5'h04;
  localparam [4:0] ST_INPOS = 5'h08;
  localparam [4:0] ST_RELEASE = 5'h10;

  localparam [31:0] MS_FULL = MS_CYCLES - 1;
  localparam [16:0] MS_LAST = MS_FULL[16:0];

  // ----------------------------------------
  // Per-axis check times and in-position
  // ----------------------------------------
  wire [`BDCG_TD_W*`BDCG_AXES-1:0] td_each;
  wire [`BDCG_TD_W*(`BDCG_AXES+1)-1:0] td_chain;
  wire [`BDCG_AXES-1:0] inpos_each;
  // Block kind held for the wait, since block_is_rapid may move on
  reg rapid_reg;

  assign td_chain[`BDCG_TD_W-1:0] = 18'h00000;

  genvar gi;
  generate
    for (gi = 0; gi < `BDCG_AXES; gi = gi + 1) begin : g_axis
      wire [1:0] mode_sel;
      wire [`BDCG_TS_W-1:0] ts_sel;
      wire [`BDCG_TD_W-1:0] td_cur;
      wire [`BDCG_TD_W-1:0] td_prev;
      wire [`BDCG_WID_W-1:0] feed_w;

      // Rapid blocks read rapid setup, cutting blocks cutting setup
      assign mode_sel = block_is_rapid ?
        rapid_accel_mode[2*gi+1:2*gi] :
        cutting_accel_mode[2*gi+1:2*gi];
      assign ts_sel = block_is_rapid ?
        rapid_time_constant[`BDCG_TS_W*gi+`BDCG_TS_W-1:`BDCG_TS_W*gi] :
        cutting_time_constant[`BDCG_TS_W*gi+`BDCG_TS_W-1:`BDCG_TS_W*gi];

      bdcg_axis_td u_td (
        .accel_mode(mode_sel),
        .accel_time_constant(ts_sel),
        .axis_commanded(axis_commanded[gi]),
        .decel_check_time(td_cur)
      );

      // Running maximum over commanded axes
      assign td_prev = td_chain[`BDCG_TD_W*gi+`BDCG_TD_W-1:`BDCG_TD_W*gi];
      assign td_chain[`BDCG_TD_W*(gi+1)+`BDCG_TD_W-1:`BDCG_TD_W*(gi+1)] =
        (td_cur > td_prev) ? td_cur : td_prev;

      // Width set follows the block held in the gate
      assign feed_w = rapid_reg ?
        rapid_axis_inpos_width[`BDCG_WID_W*gi+`BDCG_WID_W-1:
                               `BDCG_WID_W*gi] :
        cutting_axis_inpos_width[`BDCG_WID_W*gi+`BDCG_WID_W-1:
                                 `BDCG_WID_W*gi];

      bdcg_axis_inpos u_inpos (
        .servo_inpos_width(
          servo_inpos_width[`BDCG_WID_W*gi+`BDCG_WID_W-1:`BDCG_WID_W*gi]),
        .feed_axis_width(feed_w),
        .position_error(
          position_error[`BDCG_WID_W*gi+`BDCG_WID_W-1:`BDCG_WID_W*gi]),
        .in_position(inpos_each[gi])
      );
    end
  endgenerate

  wire [`BDCG_TD_W-1:0] td_max;

  assign td_max =
    td_chain[`BDCG_TD_W*(`BDCG_AXES+1)-1:`BDCG_TD_W*`BDCG_AXES];

  // ----------------------------------------
  // Method selection
  // ----------------------------------------
  reg [1:0] shared_method;
  reg [1:0] exact_cut_method;
  reg [1:0] method_next;
  reg any_reversal;
  reg reversal_check;
  reg exact_cut;

  always @* begin
    // Selector value 3 is outside the range; treated as command wait
    if (rapid_method_select == `BDCG_METH_INPOS) begin
      shared_method = `BDCG_METH_INPOS;
    end else if (rapid_method_select == `BDCG_METH_SMOOTH) begin
      shared_method = `BDCG_METH_SMOOTH;
    end else begin
      shared_method = `BDCG_METH_CMD;
    end

    if (spec_type_select) begin
      exact_cut_method = shared_method;
    end else if (cutting_smoothing_select) begin
      exact_cut_method = `BDCG_METH_SMOOTH;
    end else if (cutting_method_bit) begin
      exact_cut_method = `BDCG_METH_INPOS;
    end else begin
      exact_cut_method = `BDCG_METH_CMD;
    end
  end

  // ----------------------------------------
  // Check needed at this block end
  // ----------------------------------------
  always @* begin
    // One reversing axis is enough
    any_reversal = |(axis_reversal & axis_commanded);
    reversal_check =
      (any_reversal && next_is_rapid && cut_to_rapid_reversal_flag) ||
      (any_reversal && next_is_cut && cut_to_cut_reversal_flag);
    exact_cut = error_detect_switch || block_exact_stop ||
                exact_stop_mode;

    if (!block_moved) begin
      method_next = `BDCG_METH_NONE;
    end else if (block_is_rapid) begin
      method_next = shared_method;
    end else if (exact_cut) begin
      method_next = exact_cut_method;
    end else if (reversal_check) begin
      method_next = `BDCG_METH_CMD;
    end else begin
      method_next = `BDCG_METH_NONE;
    end
  end

  // ----------------------------------------
  // Gate sequence
  // ----------------------------------------
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [16:0] ms_div_reg;
  reg [`BDCG_TD_W-1:0] ms_left_reg;
  wire ms_tick;
  wire all_smooth;
  wire all_inpos;
  wire take_block;

  // A block end is only seen while idle; one that comes later is dropped
  assign take_block = (state_reg == ST_IDLE) && block_end;
  assign ms_tick = (ms_div_reg == MS_LAST);
  assign all_smooth = &smoothing_zero;
  assign all_inpos = &inpos_each;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (block_end) begin
          if (method_next == `BDCG_METH_NONE) begin
            state_next = ST_RELEASE;
          end else begin
            state_next = ST_DECEL;
          end
        end
      end
      ST_DECEL: begin
        if (ms_left_reg == 18'h00000) begin
          if (active_method == `BDCG_METH_SMOOTH) begin
            state_next = ST_SMOOTH;
          end else if (active_method == `BDCG_METH_INPOS) begin
            state_next = ST_INPOS;
          end else begin
            state_next = ST_RELEASE;
          end
        end
      end
      ST_SMOOTH: begin
        if (all_smooth) begin
          state_next = ST_RELEASE;
        end
      end
      ST_INPOS: begin
        // In-position also needs smoothing settled
        if (all_smooth && all_inpos) begin
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State and status outputs
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      block_release <= 1'b0;
      gate_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      block_release <= (state_next == ST_RELEASE);
      gate_busy <= (state_next != ST_IDLE) && (state_next != ST_RELEASE);
    end
  end

  // ----------------------------------------
  // Block capture
  // ----------------------------------------
  // Frozen at the taken block end, so the sequencer may move on to
  // the next block's levels while this one is still being checked
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rapid_reg <= 1'b0;
      active_method <= `BDCG_METH_NONE;
      block_completion_wait <= 18'h00000;
    end else if (take_block) begin
      rapid_reg <= block_is_rapid;
      active_method <= method_next;
      if (method_next == `BDCG_METH_NONE) begin
        block_completion_wait <= 18'h00000;
      end else begin
        block_completion_wait <= td_max;
      end
    end
  end

  // ----------------------------------------
  // Millisecond countdown
  // ----------------------------------------
  // Divider restarts at each block, so the wait is exact, not 1 ms coarse
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      ms_div_reg <= 17'h00000;
      ms_left_reg <= 18'h00000;
    end else if (take_block) begin
      ms_div_reg <= 17'h00000;
      if (method_next == `BDCG_METH_NONE) begin
        ms_left_reg <= 18'h00000;
      end else begin
        ms_left_reg <= td_max;
      end
    end else if (state_reg == ST_DECEL) begin
      if (ms_tick) begin
        ms_div_reg <= 17'h00000;
        if (ms_left_reg != 18'h00000) begin
          ms_left_reg <= ms_left_reg - 18'h00001;
        end
      end else begin
        ms_div_reg <= ms_div_reg + 17'h00001;
      end
    end
  end

endmodule // bdcg_top

`default_nettype wire

//--- block_decel_check_gate_bench.sv
// Self-checking bench for the block deceleration check gate.
// Assumes: bdcg_top, its checker and the servo axes model are compiled.
`timescale 1ns/100ps
`default_nettype none
`include "bdcg_regs.vh"

module block_decel_check_gate_bench;
  localparam int MS = 4;
  localparam logic [7:0] RMODE = 8'h24;
  localparam logic [63:0] RTS = 64'h0001_0004_0002_0003;
  localparam logic [7:0] CMODE = 8'h18;
  localparam logic [63:0] CTS = 64'h0006_0003_0002_0001;
  typedef struct packed {
    logic rp, es, em, ed, nr, nc, rv, sp;
    logic [1:0] rs;
    logic cb, cs, fr, fc, mv, p0;
    logic [3:0] ax;
    logic [1:0] p1, me;
  } bdcg_row_t;
  // Nibbles: rp es em ed | nr nc rv sp | rs cb cs | fr fc mv - | ax | me
  localparam logic [23:0] ROWS [16] = '{24'h8002F0, 24'h804211,
    24'h818222, 24'h80C240, 24'h402231, 24'h2012C2, 24'h100280,
    24'h41A2F2, 24'h215261, 24'h0A0A30, 24'h0A0213, 24'h060650,
    24'h060A23, 24'h040623, 24'h8000F3, 24'h0002F3};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic block_end = 1'b0;
  logic moving = 1'b1;
  bdcg_row_t r = '0;
  bdcg_row_t x;
  logic [16:0] sw = 17'h5, rw = 17'h0, cw = 17'h0, err0 = 17'h0;
  logic [7:0] lag = 8'h2;
  logic [17:0] td;
  logic b1;
  wire logic rel, busy;
  wire logic [1:0] meth;
  wire logic [17:0] bcw;
  wire logic [3:0] sz;
  wire logic [67:0] perr;
  int n_fail = 0, samples_checked = 0, cyc = 0, n, lo, hi;

  always #5 sys_clk = ~sys_clk;

  bdcg_top #(.MS_CYCLES(MS)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .block_end(block_end),
    .block_moved(r.mv), .block_is_rapid(r.rp), .block_exact_stop(r.es),
    .exact_stop_mode(r.em), .error_detect_switch(r.ed),
    .next_is_rapid(r.nr), .next_is_cut(r.nc), .axis_commanded(r.ax),
    .axis_reversal({3'h0, r.rv}), .spec_type_select(r.sp),
    .rapid_method_select(r.rs), .cutting_method_bit(r.cb),
    .cutting_smoothing_select(r.cs), .cut_to_rapid_reversal_flag(r.fr),
    .cut_to_cut_reversal_flag(r.fc), .rapid_accel_mode(RMODE),
    .rapid_time_constant(RTS), .cutting_accel_mode(CMODE),
    .cutting_time_constant(CTS), .servo_inpos_width({4{sw}}),
    .rapid_axis_inpos_width({4{rw}}), .cutting_axis_inpos_width({4{cw}}),
    .smoothing_zero(sz), .position_error(perr), .block_release(rel),
    .gate_busy(busy), .active_method(meth), .block_completion_wait(bcw));

  bdcg_axes_model u_axes (.sys_clk(sys_clk), .rst_b(rst_b),
    .moving(moving), .lag(lag), .err0(err0), .smoothing_zero(sz),
    .position_error(perr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [17:0] td_of(input logic rp, input logic [3:0] ax);
    logic [1:0] m;
    logic [17:0] t, best;
    best = 18'h0;
    for (int i = 0; i < 4; i++) begin
      m = rp ? RMODE[2*i+:2] : CMODE[2*i+:2];
      t = {2'h0, rp ? RTS[16*i+:16] : CTS[16*i+:16]};
      t = (m == `BDCG_MODE_EXP ? t << 1 : t) + `BDCG_MARGIN_MS;
      if (ax[i] && t > best)
        best = t;
    end
    return best;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Axes move until the block end; n counts cycles to the release
  task automatic run(input logic [23:0] row, input logic [7:0] lg,
                     input logic [16:0] e0);
    @(posedge sys_clk);
    moving <= 1'b1;
    lag <= lg;
    err0 <= e0;
    @(posedge sys_clk);
    r <= row;
    block_end <= 1'b1;
    moving <= 1'b0;
    @(posedge sys_clk);
    block_end <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n == 1)
        b1 = busy;
    end while (rel !== 1'b1 && n < 400);
  endtask

  task automatic inp(input logic [23:0] row, input logic [16:0] c,
                     input int w);
    @(posedge sys_clk);
    cw <= c;
    rw <= 17'h28;
    run(row, 8'h2, 17'h96);
    chk(n >= 150 - w && n <= 155 - w, 1'b1);
  endtask

  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run;
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({rel, busy, meth, bcw}, 22'h0C0000);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      run(ROWS[k], 8'h2, 17'h0);
      x = ROWS[k];
      chk(meth, x.me);
      td = (x.me == 2'h3) ? 18'h0 : td_of(x.rp, x.ax);
      chk(bcw, td);
      lo = (x.me == 2'h3) ? 1 : td * MS;
      hi = (x.me == 2'h3) ? 1 : td * (MS + 1) + 3;
      chk(n >= lo && n <= hi, 1'b1);
      chk(b1, x.me != 2'h3);
    end
    // Slow smoothing must hold the release back
    run(24'h818222, 8'h50, 17'h0);
    chk(n >= 79 && n <= 84, 1'b1);
    inp(24'h402231, 17'h14, 20);
    inp(24'h402231, 17'h3, 5);
    inp(24'h402231, 17'h0, 5);
    inp(24'h804211, 17'h14, 40);
    // Reset in mid-wait drops the held block; the next block runs clean
    @(posedge sys_clk);
    r <= 24'h8002F0;
    block_end <= 1'b1;
    @(posedge sys_clk);
    block_end <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk({rel, busy, meth, bcw}, 22'h0C0000);
    run(24'h8002F0, 8'h2, 17'h0);
    chk(meth, 2'h0);
    chk(bcw, td_of(1'b1, 4'hF));
    complete_run;
  end
endmodule // block_decel_check_gate_bench
`default_nettype wire
